// ---- verilog/output_power_on_reset_timer.sv ----
// Power-on reset timer for the second regulator output
`timescale 1ns/1ps
module output_power_on_reset_timer
	import por_timer_pkg::*;
#(
	parameter int unsigned P_DELAY_CYCLES = DELAY_CYCLES  // Release delay, shorten in sim
)
(
	input  wire logic i_ref_clk,           // Internal oscillator clock
	input  wire logic i_rst_n,             // Supply-present reset, active low
	input  wire logic i_run_softstart_one, // Run input one above 1.3V
	input  wire logic i_run_softstart_two, // Run input two above 1.3V
	input  wire logic i_out_start_ok,      // Output within five percent
	input  wire logic i_out_droop,         // Output more than 7.5 percent low
	input  wire logic i_low_batt_trip,     // Low-battery comparator raw trip
	input  wire logic i_reset_flag_output, // Level seen on the flag pin
	output logic      o_reset_flag_output, // Flag pin output value, always low
	output logic      o_reset_flag_oe,     // Flag pull-down enable
	output logic      o_ctrl_one_en,       // Controller one enable
	output logic      o_ctrl_two_en,       // Controller two enable
	output logic      o_low_batt_n         // Low-battery pull-down enable, active high
);

	//******************************************************************
	// Input synchronisation
	//******************************************************************
	sense_s sense;                         // Synchronised inputs
	logic   shutdown;                      // Both run inputs low
	logic   pin_sync;                      // Flag pin level, synchronised

	sync_2ff u_sync_run1 (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_async(i_run_softstart_one), .o_sync(sense.run_one));
	sync_2ff u_sync_run2 (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_async(i_run_softstart_two), .o_sync(sense.run_two));
	sync_2ff u_sync_start (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_async(i_out_start_ok), .o_sync(sense.out_start));
	sync_2ff u_sync_droop (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_async(i_out_droop), .o_sync(sense.out_droop));
	sync_2ff u_sync_lbat (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_async(i_low_batt_trip), .o_sync(sense.low_batt));
	sync_2ff u_sync_pin (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_async(i_reset_flag_output), .o_sync(pin_sync));

	// Shutdown when neither controller runs
	assign shutdown = !sense.run_one && !sense.run_two;

	//******************************************************************
	// Controller enables and low-battery gating
	//******************************************************************
	// Each controller follows only its own run input
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_ctrl_one_en <= 1'b0;
			o_ctrl_two_en <= 1'b0;
		end
		else
		begin
			o_ctrl_one_en <= sense.run_one;
			o_ctrl_two_en <= sense.run_two;
		end
	end

	// Low-battery output released in shutdown
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_low_batt_n <= 1'b0;
		else
			o_low_batt_n <= sense.low_batt && !shutdown;
	end

	//******************************************************************
	// Droop filter
	//******************************************************************
	logic [DROOP_W-1:0] droop_cnt;         // Cycles of continuous droop
	logic               droop_fault;       // Droop lasted long enough

	// Count consecutive droop cycles, saturate at limit
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			droop_cnt <= '0;
		else if (!sense.out_droop)
			droop_cnt <= '0;
		else if (droop_cnt != DROOP_W'(DROOP_CYCLES))
			droop_cnt <= droop_cnt + DROOP_W'(1);
	end

	assign droop_fault = (droop_cnt == DROOP_W'(DROOP_CYCLES));

	//******************************************************************
	// Release sequencer
	//******************************************************************
	por_state_e       state;               // Sequencer state
	por_state_e       next_state;          // Next sequencer state
	logic [CNT_W-1:0] delay_cnt;           // Release delay counter
	logic             count_done;          // Delay reached

	assign count_done = (delay_cnt == CNT_W'(P_DELAY_CYCLES - 1));

	// Next-state selection
	always_comb
	begin
		next_state = state;
		case (state)
			ST_HOLD:
			begin
				if (!shutdown && sense.out_start)
					next_state = ST_COUNT;
			end
			ST_COUNT:
			begin
				if (shutdown || !sense.out_start)
					next_state = ST_HOLD;
				else if (count_done)
					next_state = ST_READY;
			end
			ST_READY:
			begin
				if (shutdown || droop_fault)
					next_state = ST_HOLD;
			end
			default:
				next_state = ST_HOLD;
		endcase
	end

	// State register; reset is the power-up hold
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			state <= ST_HOLD;
		else
			state <= next_state;
	end

	// Delay counter, cleared outside counting
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			delay_cnt <= '0;
		else if (state == ST_COUNT && next_state == ST_COUNT)
			delay_cnt <= delay_cnt + CNT_W'(1);
		else
			delay_cnt <= '0;
	end

	//******************************************************************
	// Open-drain flag driver
	//******************************************************************
	// Pull-down on unless released; runs in shutdown too
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_reset_flag_oe <= 1'b1;
		else
			o_reset_flag_oe <= (next_state != ST_READY);
	end

	assign o_reset_flag_output = 1'b0;              // Open drain drives low only

	//******************************************************************
	// Assertions
	//******************************************************************
	property p_hold_pulls;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(state == ST_HOLD) |-> o_reset_flag_oe;
	endproperty
	a_hold_pulls: assert property (p_hold_pulls)
		else $error("flag released while holding");

	property p_shutdown_low;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		shutdown |=> o_reset_flag_oe;
	endproperty
	a_shutdown_low: assert property (p_shutdown_low)
		else $error("flag not forced low in shutdown");

	property p_start_count;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(state == ST_HOLD && !shutdown && sense.out_start) |=> (state == ST_COUNT);
	endproperty
	a_start_count: assert property (p_start_count)
		else $error("count did not start");

	property p_release;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(state == ST_COUNT && count_done && !shutdown && sense.out_start)
			|=> (state == ST_READY && !o_reset_flag_oe);
	endproperty
	a_release: assert property (p_release)
		else $error("flag not released at count end");

	property p_no_early;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		$rose(state == ST_READY) |-> $past(count_done);
	endproperty
	a_no_early: assert property (p_no_early)
		else $error("released before full count");

	property p_droop;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(state == ST_READY && droop_fault) |=> o_reset_flag_oe;
	endproperty
	a_droop: assert property (p_droop)
		else $error("droop did not reassert flag");

	property p_short_droop;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(state == ST_READY && !shutdown && sense.out_droop && droop_cnt == '0)
			|=> !o_reset_flag_oe;
	endproperty
	a_short_droop: assert property (p_short_droop)
		else $error("short droop reasserted flag");

	property p_abort;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(state == ST_COUNT && !sense.out_start) |=> (delay_cnt == '0 && o_reset_flag_oe);
	endproperty
	a_abort: assert property (p_abort)
		else $error("counter not cleared on early drop");

	property p_lbat;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		shutdown |=> !o_low_batt_n;
	endproperty
	a_lbat: assert property (p_lbat)
		else $error("low-battery active in shutdown");

	property p_enable;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		1'b1 |=> (o_ctrl_one_en == $past(sense.run_one) && o_ctrl_two_en == $past(sense.run_two));
	endproperty
	a_enable: assert property (p_enable)
		else $error("controller enable mismatch");

	c_release: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		$rose(state == ST_READY));
	c_droop: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		state == ST_READY && droop_fault);
	c_abort: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		state == ST_COUNT && !sense.out_start);
	c_pin_low: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		state == ST_READY && !pin_sync);

endmodule : output_power_on_reset_timer

// ---- common/por_timer_pkg.sv ----
// Constants and carriers for the output power-on reset timer
//**********************************************************************
// Notes on behaviour
// - Pull reset flag low while output unregulated
// - Hold flag low at power-up and wake
// - Start count when output within five percent
// - Release flag after 65536 counted clock cycles
// - Reassert after 7.5 percent droop lasting thirty microseconds
// - Shutdown forces flag low regardless of output
// - Flag driver stays active during shutdown
// - Each controller enabled by its own run input
// - Low-battery output disabled during shutdown
//**********************************************************************
package por_timer_pkg;

	localparam int unsigned CLK_FREQ_HZ   = 25_000_000;       // Reference clock rate
	localparam int unsigned DELAY_CYCLES  = 65536;            // Release delay count
	localparam int unsigned CNT_W         = 17;               // Delay counter width
	localparam int unsigned DROOP_TIME_NS = 30_000;           // Droop filter time
	localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
	localparam int unsigned DROOP_CYCLES  = DROOP_TIME_NS / CLK_PERIOD_NS; // Rounded down
	localparam int unsigned DROOP_W       = 10;               // Droop counter width

	// Synchronised comparator and run inputs
	typedef struct packed {
		logic run_one;      // Run input one above enable level
		logic run_two;      // Run input two above enable level
		logic out_start;    // Output above start threshold
		logic out_droop;    // Output below droop threshold
		logic low_batt;     // Raw low-battery comparator trip
	} sense_s;

	// Timer state
	typedef enum logic [2:0] {
		ST_HOLD  = 3'b001,  // Flag held low, counter idle
		ST_COUNT = 3'b010,  // Counting towards release
		ST_READY = 3'b100   // Flag released
	} por_state_e;

endpackage : por_timer_pkg

// ---- verilog/sync_2ff.sv ----
// Two-flop synchroniser, one bit
`timescale 1ns/1ps
module sync_2ff
(
	input  wire logic i_ref_clk,   // Reference clock
	input  wire logic i_rst_n,     // Asynchronous reset, active low
	input  wire logic i_async,     // Asynchronous level
	output logic      o_sync       // Synchronised level
);
	logic stage1;                  // First stage, read only by second

	// Two-stage capture
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			stage1 <= 1'b0;
			o_sync <= 1'b0;
		end
		else
		begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule : sync_2ff

// ---- sim/flag_pullup_model.sv ----
// Pull-up model of the system logic listening on the reset flag wire
`timescale 1ns/1ps
module flag_pullup_model
(
	input  wire logic i_flag_oe,    // Device pull-down enable
	input  wire logic i_flag_data,  // Device open-drain data, low
	output logic      o_flag_level  // Resolved wire level
);
	//**********************************************************
	// Wire resolution
	//**********************************************************
	// Pull-up wins unless the device pulls the wire down
	assign o_flag_level = i_flag_oe ? i_flag_data : 1'b1;
endmodule : flag_pullup_model

// ---- sim/output_power_on_reset_timer_test.sv ----
// Self-checking bench for the output power-on reset timer
`timescale 1ns/1ps
module output_power_on_reset_timer_test import por_timer_pkg::*;;
	//**********************************************************
	// Stimulus and observed nets
	//**********************************************************
	localparam int unsigned DLY   = 16;    // Shortened release delay
	localparam int          LIMIT = 5000;  // Cycle ceiling for a hang
	logic ref_clk  = 1'b0;  // 25 MHz clock
	logic rst_n    = 1'b0;  // Supply-present reset
	logic run_one  = 1'b0;  // Run input one
	logic run_two  = 1'b0;  // Run input two
	logic start_ok = 1'b0;  // Output within start window
	logic droop    = 1'b0;  // Output droop indication
	logic lb_trip  = 1'b0;  // Raw low-battery trip
	logic flag_data, flag_oe, flag_level, en_one, en_two, lb_n;
	int   mismatches = 0;   // Failed comparisons
	int   n_tests    = 0;   // All comparisons
	int   cycles     = 0;   // Clock cycles run
	// Free-running clock
	always #20 ref_clk = ~ref_clk;
	output_power_on_reset_timer #(.P_DELAY_CYCLES(DLY)) u_dut (
		.i_ref_clk(ref_clk), .i_rst_n(rst_n),
		.i_run_softstart_one(run_one), .i_run_softstart_two(run_two),
		.i_out_start_ok(start_ok), .i_out_droop(droop),
		.i_low_batt_trip(lb_trip), .i_reset_flag_output(flag_level),
		.o_reset_flag_output(flag_data), .o_reset_flag_oe(flag_oe),
		.o_ctrl_one_en(en_one), .o_ctrl_two_en(en_two), .o_low_batt_n(lb_n));
	flag_pullup_model u_sys (
		.i_flag_oe(flag_oe), .i_flag_data(flag_data), .o_flag_level(flag_level));
	//**********************************************************
	// Shared tasks
	//**********************************************************
	// Compare and count
	task automatic check(input string name, input logic exp, input logic got);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %b seen %b", name, exp, got);
		end
	endtask : check
	// Step to a later falling edge
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick
	// Counts and verdict
	task automatic close_out;
		$display("Comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	//**********************************************************
	// Scenarios
	//**********************************************************
	// Outputs straight after reset
	task automatic test_reset;
		check("oe_reset", 1'b1, flag_oe);
		check("level_reset", 1'b0, flag_level);
		check("en_one_reset", 1'b0, en_one);
		check("en_two_reset", 1'b0, en_two);
		check("lb_reset", 1'b0, lb_n);
		$display("test_reset done");
	endtask : test_reset
	// Full count then release
	task automatic test_release;
		run_one = 1'b1;
		run_two = 1'b1;
		tick(4);
		check("level_wait", 1'b0, flag_level);
		start_ok = 1'b1;
		// Two sync edges, one state edge, then the full count
		tick(DLY + 2);
		check("oe_early", 1'b1, flag_oe);
		tick(1);
		check("oe_released", 1'b0, flag_oe);
		check("level_released", 1'b1, flag_level);
		$display("test_release done");
	endtask : test_release
	// Short droop filtered, long droop reasserts
	task automatic test_droop;
		// A drooping output is also outside the start window
		droop = 1'b1;
		start_ok = 1'b0;
		tick(700);
		droop = 1'b0;
		start_ok = 1'b1;
		tick(4);
		check("oe_short_droop", 1'b0, flag_oe);
		droop = 1'b1;
		start_ok = 1'b0;
		// Filter saturates two sync edges plus the droop time later
		tick(752);
		check("oe_droop_edge", 1'b0, flag_oe);
		tick(1);
		check("oe_long_droop", 1'b1, flag_oe);
		check("level_long_droop", 1'b0, flag_level);
		droop = 1'b0;
		tick(4);
		$display("test_droop done");
	endtask : test_droop
	// Drop mid-count clears the counter
	task automatic test_early_drop;
		start_ok = 1'b1;
		tick(DLY / 2);
		start_ok = 1'b0;
		tick(4);
		check("oe_dropped", 1'b1, flag_oe);
		start_ok = 1'b1;
		// A stale count would release before this point
		tick(DLY + 2);
		check("oe_recount", 1'b1, flag_oe);
		tick(1);
		check("oe_rereleased", 1'b0, flag_oe);
		$display("test_early_drop done");
	endtask : test_early_drop
	// Every run combination, shutdown last
	task automatic test_shutdown;
		lb_trip = 1'b1;
		for (int i = 3; i >= 0; i--)
		begin
			run_one = i[0];
			run_two = i[1];
			tick(4);
			check("en_one", i[0], en_one);
			check("en_two", i[1], en_two);
			check("lb_gate", (i != 0), lb_n);
			check("oe_shutdown", (i == 0), flag_oe);
			check("level_shutdown", (i != 0), flag_level);
		end
		run_one = 1'b1;
		lb_trip = 1'b0;
		tick(4);
		check("lb_clear", 1'b0, lb_n);
		$display("test_shutdown done");
	endtask : test_shutdown
	//**********************************************************
	// Sequence and hang guard
	//**********************************************************
	// Main sequence
	initial
	begin
		tick(10);
		rst_n = 1'b1;
		tick(2);
		test_reset;
		test_release;
		test_droop;
		test_early_drop;
		test_shutdown;
		close_out;
	end
	// Cycle ceiling
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			mismatches++;
			close_out;
		end
	end
endmodule : output_power_on_reset_timer_test
